//--- tb/sector_lock_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// checker on the sector lock ports
// ****
module sector_lock_sva
  import lock_reg_pkg::*;
(
  // clock and reset
  input wire logic                 i_core_clk,
  input wire logic                 i_rst_n,
  // serial port
  input wire logic                 i_spi_sel_n,
  input wire logic                 i_spi_sclk,
  input wire logic                 i_spi_mosi,
  input wire logic                 o_serial_data_out,
  input wire logic                 o_serial_data_out_oe,
  // array side
  input wire logic                 i_busy,
  input wire logic                 i_op_req,
  input wire logic [ADDR_BITS-1:0] i_op_addr,
  input wire logic                 o_op_done,
  input wire logic                 o_op_allowed,
  input wire logic                 o_wel
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // busy on every cycle of this frame so far
  logic busy_q;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) busy_q <= 1'b1;
    else busy_q <= i_spi_sel_n | (busy_q & i_busy);
  end
  sequence s_sel_end;
    i_spi_sel_n [*3];
  endsequence
  a_query_done: assert property (i_op_req |=> o_op_done)
    else $error("query not answered");
  a_done_cause: assert property (o_op_done |-> $past(i_op_req))
    else $error("answer without query");
  a_allow_hold: assert property ($changed(o_op_allowed) |-> o_op_done)
    else $error("allowed moved without answer");
  // the fall is seen one edge before oe shows, so look two and one samples back
  a_oe_on_fall: assert property ($rose(o_serial_data_out_oe) |->
    $past(i_spi_sclk, 2) && !$past(i_spi_sclk))
    else $error("output started off a fall");
  a_data_hold: assert property (o_serial_data_out_oe && $past(o_serial_data_out_oe)
    && !($past(i_spi_sclk, 2) && !$past(i_spi_sclk)) |-> $stable(o_serial_data_out))
    else $error("data moved off a fall");
  a_sel_stop: assert property (s_sel_end |-> !o_serial_data_out_oe && !o_serial_data_out)
    else $error("still driving after select high");
  a_idle_low: assert property (!o_serial_data_out_oe |-> !o_serial_data_out)
    else $error("data high while released");
  a_busy_quiet: assert property (busy_q && i_busy && !i_spi_sel_n |-> !o_serial_data_out_oe)
    else $error("output during busy");
  a_wel_at_end: assert property ($changed(o_wel) |-> $past(i_spi_sel_n) ||
    $past(i_spi_sel_n, 2))
    else $error("latch moved inside a frame");
endmodule : sector_lock_sva
`default_nettype wire

//--- tb/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// serial host: mode 0, clock still outside frames
// ****
module spi_host_model (
  input  wire logic i_clk,
  input  wire logic i_dout,
  output var logic  o_sel_n,
  output var logic  o_sclk,
  output var logic  o_mosi
);
  initial begin
    o_sel_n = 1'b1;
    o_sclk  = 1'b0;
    o_mosi  = 1'b0;
  end
  // n bits of v out msb first, then nrd bits in; half periods of two core cycles
  task frame(input logic [39:0] v, input int n, input int nrd, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    @(posedge i_clk) o_sel_n <= 1'b0;
    for (i = 0; i < n + nrd; i++) begin
      @(posedge i_clk);
      o_sclk <= 1'b0;
      o_mosi <= (i < n) ? v[39-i] : ~o_mosi;
      @(posedge i_clk);
      @(posedge i_clk);
      o_sclk <= 1'b1;
      if (i >= n) rd = {rd[6:0], i_dout};
      @(posedge i_clk);
    end
    @(posedge i_clk) o_sclk <= 1'b0;
    repeat (2) @(posedge i_clk);
    o_sel_n <= 1'b1;
    o_mosi  <= ~o_mosi; // released line never holds its last value
    repeat (4) @(posedge i_clk);
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// sector lock bench
// ****
module tb;
  import lock_reg_pkg::*;
  logic                 i_core_clk = 1'b0;
  logic                 i_rst_n    = 1'b0;
  logic                 i_busy     = 1'b0;
  logic                 i_op_req   = 1'b0;
  logic [ADDR_BITS-1:0] i_op_addr  = '0;
  logic                 sel_n, sclk, mosi, dout, oe, done, allowed, wel, oe_seen;
  logic [7:0]           rd;
  int                   fails = 0, n_checks = 0, cycles = 0;
  always #20 i_core_clk = ~i_core_clk;
  sector_lock uut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_spi_sel_n(sel_n),
    .i_spi_sclk(sclk), .i_spi_mosi(mosi), .o_serial_data_out(dout),
    .o_serial_data_out_oe(oe), .i_busy(i_busy), .i_op_req(i_op_req),
    .i_op_addr(i_op_addr), .o_op_done(done), .o_op_allowed(allowed), .o_wel(wel));
  spi_host_model host (.i_clk(i_core_clk), .i_dout(dout), .o_sel_n(sel_n),
    .o_sclk(sclk), .o_mosi(mosi));
  // remember any drive; cleared by the busy test before use
  always @(posedge i_core_clk) begin
    if (oe === 1'b1) oe_seen <= 1'b1;
    cycles++;
    if (cycles == 12000) begin
      fails++;
      $display("[FAIL] %0t timeout", $time);
      end_of_test();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task rd_lock(input logic [23:0] a, input logic [7:0] exp);
    host.frame({OPC_LOCK_READ, a, 8'h00}, 32, 8, rd);
    chk(rd, exp, "lock byte");
  endtask : rd_lock
  task wr_lock(input logic [23:0] a, input logic [7:0] b);
    host.frame({OPC_LOCK_WRITE, a, b}, 40, 0, rd);
  endtask : wr_lock
  task wren();
    host.frame({OPC_WR_ENABLE, 32'h0}, 8, 0, rd);
    chk({7'h0, wel}, 8'h01, "latch set");
  endtask : wren
  task query(input logic [23:0] a, input logic exp);
    @(posedge i_core_clk);
    i_op_req  <= 1'b1;
    i_op_addr <= a;
    @(posedge i_core_clk) i_op_req <= 1'b0;
    #1 chk({6'h0, done, allowed}, {7'h1, exp}, "query");
  endtask : query
  task t_reset();
    rd_lock(24'h03_1234, RST_BYTE);
    query(24'h03_1234, 1'b1);
    $display("test reset done");
  endtask : t_reset
  task t_lock();
    wr_lock(24'h05_ABCD, 8'h01);
    rd_lock(24'h05_0000, 8'h00);
    wren();
    wr_lock(24'h05_ABCD, 8'h01);
    chk({7'h0, wel}, 8'h00, "latch cleared");
    rd_lock(24'h05_0000, 8'h01);
    query(24'h05_FFFF, 1'b0);
    query(24'h06_0000, 1'b1);
    $display("test lock done");
  endtask : t_lock
  task t_down();
    wren();
    wr_lock(24'h05_0010, 8'h03);
    rd_lock(24'h05_7000, 8'h03);
    wren();
    wr_lock(24'h05_0010, 8'h00);
    rd_lock(24'h05_0000, 8'h03);
    query(24'h05_0000, 1'b0);
    $display("test lockdown done");
  endtask : t_down
  task t_busy();
    oe_seen <= 1'b0;
    i_busy  <= 1'b1;
    host.frame({OPC_LOCK_READ, 24'h05_0000, 8'h00}, 32, 8, rd);
    chk({7'h0, oe_seen}, 8'h00, "busy read drove");
    i_busy <= 1'b0;
    rd_lock(24'h05_0000, 8'h03);
    $display("test busy done");
  endtask : t_busy
  task t_abort();
    host.frame({OPC_LOCK_READ, 24'h05_0000, 8'h00}, 32, 3, rd);
    chk({6'h0, oe, dout}, 8'h00, "abort release");
    rd_lock(24'h0F_0000, 8'h00);
    $display("test abort done");
  endtask : t_abort
  task end_of_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // main sequence after a six cycle reset
  initial begin
    repeat (6) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (5) @(posedge i_core_clk);
    t_reset();
    t_lock();
    t_down();
    t_busy();
    t_abort();
    end_of_test();
  end
endmodule : tb
bind sector_lock sector_lock_sva chk_i (.i_core_clk, .i_rst_n, .i_spi_sel_n, .i_spi_sclk,
  .i_spi_mosi, .o_serial_data_out, .o_serial_data_out_oe, .i_busy, .i_op_req, .i_op_addr,
  .o_op_done, .o_op_allowed, .o_wel);
`default_nettype wire

//--- verilog/lock_cell.sv
`timescale 1ns/1ps
`default_nettype none

module lock_cell
  import lock_reg_pkg::*;
#(
  parameter int SUB_N   = 16,
  parameter bit HAS_SUB = 1'b0
) (
  // clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  // write strobe with the received lock byte
  input  wire logic                     i_wr,
  input  wire logic [7:0]               i_byte,
  input  wire logic [$clog2(SUB_N)-1:0] i_sub,
  // stored lock state
  output logic                          o_wr_lock,
  output logic                          o_lock_down,
  output logic                          o_sub_lock_down,
  output logic [SUB_N-1:0]              o_sub_wr_lock
);

  typedef struct packed {
    logic             wl;
    logic             ld;
    logic             sld;
    logic [SUB_N-1:0] swl;
  } cell_t;

  cell_t c_q;
  cell_t c_d;

  // lock-down freezes its own pair of bits until reset
  always_comb begin
    c_d = c_q;
    if (i_wr && !c_q.ld) begin
      c_d.wl = i_byte[BIT_WR_LOCK];
      c_d.ld = i_byte[BIT_LOCK_DOWN];
    end
    // subsector bits exist only where the variant provides them
    if (HAS_SUB && i_wr && !c_q.sld) begin
      c_d.swl[i_sub] = i_byte[BIT_SUB_WR_LOCK];
      c_d.sld        = i_byte[BIT_SUB_LK_DOWN];
    end
  end

  // power-up clears every lock bit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  assign o_wr_lock       = c_q.wl;
  assign o_lock_down     = c_q.ld;
  assign o_sub_lock_down = c_q.sld;
  assign o_sub_wr_lock   = c_q.swl;

endmodule : lock_cell

`default_nettype wire

//--- verilog/lock_reg_pkg.sv
package lock_reg_pkg;

  // ************************************************************
  // command codes, bit positions and sizes
  // ************************************************************
  localparam logic [7:0] OPC_WR_ENABLE  = 8'h06;
  localparam logic [7:0] OPC_WR_DISABLE = 8'h04;
  localparam logic [7:0] OPC_LOCK_READ  = 8'hE8;
  localparam logic [7:0] OPC_LOCK_WRITE = 8'hE5;

  localparam int OPC_BITS  = 8;   // opcode length in serial clocks
  localparam int ADDR_BITS = 24;  // three address bytes
  localparam int DATA_BITS = 8;   // one lock byte

  // lock byte field positions
  localparam int BIT_WR_LOCK     = 0;
  localparam int BIT_LOCK_DOWN   = 1;
  localparam int BIT_SUB_WR_LOCK = 2;
  localparam int BIT_SUB_LK_DOWN = 3;

  // address slicing: sector and subsector index positions
  localparam int SECT_LSB = 16;
  localparam int SUB_LSB  = 12;

  // values after reset
  localparam logic       RST_LOCK_BIT = 1'b0;
  localparam logic [7:0] RST_BYTE     = 8'h00;

  // command sequencer, gray along idle-opcode-address-output
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_OPC    = 3'h1,
    ST_ADDR   = 3'h3,
    ST_OUT    = 3'h2,
    ST_DATA   = 3'h6,
    ST_HOLD   = 3'h7,
    ST_IGNORE = 3'h5
  } seq_state_t;

endpackage : lock_reg_pkg

//--- verilog/sector_lock.sv
`timescale 1ns/1ps
`default_nettype none

module sector_lock
  import lock_reg_pkg::*;
#(
  parameter int N_SECT = 16,
  parameter int SUB_N  = 16,
  parameter bit LEGACY = 1'b0
) (
  // clock and reset
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rst_n,
  // serial port, sampled on the core clock
  input  wire logic                      i_spi_sel_n,
  input  wire logic                      i_spi_sclk,
  input  wire logic                      i_spi_mosi,
  output logic                           o_serial_data_out,
  output logic                           o_serial_data_out_oe,
  // array controller status
  input  wire logic                      i_busy,
  // protection query from the array controller
  input  wire logic                      i_op_req,
  input  wire logic [ADDR_BITS-1:0]      i_op_addr,
  output logic                           o_op_done,
  output logic                           o_op_allowed,
  // write-enable latch
  output logic                           o_wel
);

  localparam int SW = $clog2(N_SECT);
  localparam int BW = $clog2(SUB_N);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    seq_state_t           st;
    logic                 sclk;
    logic                 sel_n;
    logic [4:0]           cnt;
    logic [7:0]           opc;
    logic [ADDR_BITS-1:0] addr;
    logic [7:0]           din;
    logic [7:0]           sh;
    logic                 wel;
    logic                 dout;
    logic                 oe;
    logic                 done;
    logic                 allowed;
  } core_t;

  core_t s_q;
  core_t s_d;
  logic [1:0] rst_sync_q;
  logic       rst_n_s;

  // ************************************************************
  // reset release
  // ************************************************************
  // assert at once, release two clocks later to avoid a ragged exit
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync_q[1];

  // ************************************************************
  // lock storage, one cell per sector
  // ************************************************************
  logic [N_SECT-1:0] wl_v;
  logic [N_SECT-1:0] ld_v;
  logic [N_SECT-1:0] sld_v;
  logic [SUB_N-1:0]  swl_v [N_SECT];
  logic [N_SECT-1:0] wr_v;
  logic              wr_go;
  logic [SW-1:0]     wr_sect;
  logic [BW-1:0]     wr_sub;

  // address bits beyond the sector and subsector index are don't care
  assign wr_sect = s_q.addr[SECT_LSB +: SW];
  assign wr_sub  = s_q.addr[SUB_LSB +: BW];

  // the commit happens on select rising right after the data byte
  assign wr_go = !s_q.sel_n && i_spi_sel_n && (s_q.st == ST_HOLD)
                 && (s_q.opc == OPC_LOCK_WRITE)
                 && s_q.wel && !i_busy;

  for (genvar g = 0; g < N_SECT; g++) begin : g_cell
    assign wr_v[g] = wr_go && (wr_sect == SW'(g));
    lock_cell #(
      .SUB_N   (SUB_N),
      .HAS_SUB (LEGACY && (g == 0 || g == N_SECT - 1))
    ) u_cell (
      .i_clk           (i_core_clk),
      .i_rst_n         (rst_n_s),
      .i_wr            (wr_v[g]),
      .i_byte          (s_q.din),
      .i_sub           (wr_sub),
      .o_wr_lock       (wl_v[g]),
      .o_lock_down     (ld_v[g]),
      .o_sub_lock_down (sld_v[g]),
      .o_sub_wr_lock   (swl_v[g])
    );
  end

  // ************************************************************
  // lock byte lookup
  // ************************************************************
  // sector-only format unless the legacy variant is built
  function automatic logic [7:0] lock_byte(input logic [ADDR_BITS-1:0] a);
    logic [SW-1:0] sec;
    logic [BW-1:0] sub;
    logic [7:0]    b;
    sec = a[SECT_LSB +: SW];
    sub = a[SUB_LSB +: BW];
    b   = RST_BYTE;
    b[BIT_WR_LOCK]   = wl_v[sec];
    b[BIT_LOCK_DOWN] = ld_v[sec];
    if (LEGACY) begin
      b[BIT_SUB_WR_LOCK] = swl_v[sec][sub];
      b[BIT_SUB_LK_DOWN] = sld_v[sec];
    end
    return b;
  endfunction : lock_byte

  // ************************************************************
  // serial sequencer
  // ************************************************************
  logic rise;
  logic fall;
  logic [7:0] rd_byte;
  logic [ADDR_BITS-1:0] q_addr;
  logic [SW-1:0] q_sect;
  logic [BW-1:0] q_sub;

  assign rise    = i_spi_sclk && !s_q.sclk;
  assign fall    = !i_spi_sclk && s_q.sclk;
  assign rd_byte = lock_byte(s_q.addr);
  assign q_addr  = i_op_addr;
  assign q_sect  = q_addr[SECT_LSB +: SW];
  assign q_sub   = q_addr[SUB_LSB +: BW];

  // one process walks opcode, address, data and output phases
  always_comb begin
    s_d       = s_q;
    s_d.sclk  = i_spi_sclk;
    s_d.sel_n = i_spi_sel_n;
    s_d.done  = 1'b0;
    if (i_spi_sel_n) begin
      // deselect ends any phase and releases the output
      s_d.st   = ST_IDLE;
      s_d.oe   = 1'b0;
      s_d.dout = 1'b0;
      s_d.cnt  = 5'h0;
      if (!s_q.sel_n && s_q.st == ST_HOLD) begin
        unique case (s_q.opc)
          OPC_WR_ENABLE:  s_d.wel = 1'b1;
          OPC_WR_DISABLE: s_d.wel = 1'b0;
          OPC_LOCK_WRITE: if (wr_go) s_d.wel = 1'b0;
          default:        s_d.wel = s_q.wel;
        endcase
      end
    end else begin
      unique case (s_q.st)
        ST_IDLE: begin
          s_d.st  = ST_OPC;
          s_d.cnt = 5'h0;
        end
        ST_OPC: begin
          if (rise) begin
            s_d.opc = {s_q.opc[6:0], i_spi_mosi};
            s_d.cnt = s_q.cnt + 5'h1;
            if (s_q.cnt == 5'(OPC_BITS - 1)) begin
              s_d.cnt = 5'h0;
              unique case (s_d.opc)
                OPC_WR_ENABLE, OPC_WR_DISABLE: s_d.st = ST_HOLD;
                // lock commands are dropped while a cycle runs
                OPC_LOCK_READ, OPC_LOCK_WRITE:
                  s_d.st = i_busy ? ST_IGNORE : ST_ADDR;
                default: s_d.st = ST_IGNORE;
              endcase
            end
          end
        end
        ST_ADDR: begin
          if (rise) begin
            s_d.addr = {s_q.addr[ADDR_BITS-2:0], i_spi_mosi};
            s_d.cnt  = s_q.cnt + 5'h1;
            if (s_q.cnt == 5'(ADDR_BITS - 1)) begin
              s_d.cnt = 5'h0;
              s_d.st  = (s_q.opc == OPC_LOCK_READ) ? ST_OUT : ST_DATA;
            end
          end
        end
        ST_OUT: begin
          // byte reloads every eight clocks so a long read repeats it
          if (fall) begin
            s_d.oe = 1'b1;
            if (s_q.cnt == 5'h0) begin
              s_d.dout = rd_byte[7];
              s_d.sh   = {rd_byte[6:0], 1'b0};
            end else begin
              s_d.dout = s_q.sh[7];
              s_d.sh   = {s_q.sh[6:0], 1'b0};
            end
            s_d.cnt = (s_q.cnt == 5'(DATA_BITS - 1)) ? 5'h0 : s_q.cnt + 5'h1;
          end
        end
        ST_DATA: begin
          if (rise) begin
            s_d.din = {s_q.din[6:0], i_spi_mosi};
            s_d.cnt = s_q.cnt + 5'h1;
            if (s_q.cnt == 5'(DATA_BITS - 1)) begin
              s_d.cnt = 5'h0;
              s_d.st  = ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          // any extra clock means a malformed command: drop it
          if (rise) begin
            s_d.st = ST_IGNORE;
          end
        end
        ST_IGNORE: begin
          s_d.st = ST_IGNORE;
        end
        default: begin
          s_d.st = ST_IGNORE;
        end
      endcase
    end
    // protection query: sector and subsector write locks both gate
    if (i_op_req) begin
      s_d.done    = 1'b1;
      s_d.allowed = !wl_v[q_sect] && !swl_v[q_sect][q_sub];
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      s_q       <= '0;
      s_q.st    <= ST_IDLE;
      s_q.sclk  <= 1'b0;
      s_q.sel_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_serial_data_out    = s_q.dout;
  assign o_serial_data_out_oe = s_q.oe;
  assign o_op_done            = s_q.done;
  assign o_op_allowed         = s_q.allowed;
  assign o_wel                = s_q.wel;

endmodule : sector_lock

`default_nettype wire
